// *** verilog/code_map.sv ***
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - First fetch after reset is address 0000H.
// - Interrupt vectors 8 bytes apart from 0003H.
// - Timer0 000BH, int1 0013H, timer1 001BH.
// - Loader boot remaps zero and all vectors.
// - Application bank 32k or 16k, also readable.
// - Flash: four banks of 256-byte pages.
// - Flash ops: page erase, byte program, read.
// - Flash ops from tool pins or in-system.
// - Data space separate from code space.
// - 256 scratch bytes, 64k external data.
// - External data: 16/8-bit address, read/write strobes.
// - 1k auxiliary RAM via external data move.
// - Six-clock mode: address latch at fosc/3.
// - Select high: beyond bank size goes external.
// - Select low: all fetches external.
// - Select level latched once after reset.
module code_map (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_external_access_select,
  input wire logic i_boot_loader,
  input wire logic i_six_clock_cycle_mode,
  input wire logic i_app_16k,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_pc,
  input wire logic i_int_accept,
  input wire logic [2:0] i_int_idx,
  input wire logic i_data_req,
  input wire logic i_data_scratch,
  input wire logic i_data_we,
  input wire logic i_data_wide,
  input wire logic i_auxiliary_ram_en,
  input wire logic [15:0] i_data_addr,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_tool_req,
  input wire logic [1:0] i_tool_op,
  input wire logic [16:0] i_tool_addr,
  input wire logic i_isp_req,
  input wire logic [1:0] i_isp_op,
  input wire logic [16:0] i_isp_addr,
  output logic o_vector_load,
  output logic [15:0] o_vector_pc,
  output logic o_code_rd,
  output logic [16:0] o_code_addr,
  output logic o_prog_strobe_n,
  output logic [15:0] o_ext_addr,
  output logic o_ext_addr_oe_n,
  output logic o_ext_rd_n,
  output logic o_ext_wr_n,
  output logic [7:0] o_ext_wdata,
  output logic o_ext_wdata_oe_n,
  output logic o_addr_latch,
  output logic o_scratch_sel,
  output logic [7:0] o_scratch_addr,
  output logic [7:0] o_auxiliary_ram_rdata,
  output logic o_auxiliary_ram_rvalid,
  output logic o_flash_go,
  output logic [1:0] o_flash_op,
  output logic [1:0] o_flash_bank,
  output logic [6:0] o_flash_page,
  output logic [7:0] o_flash_byte,
  output logic o_flash_from_tool
);
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] pin_s1_q, pin_s2_q;
  code_map_pkg::map_state_t state_q, state_d;
  logic [1:0] start_q, start_d;
  logic ext_lat_q, ext_lat_d, ldr_lat_q, ldr_lat_d, six_lat_q, six_lat_d;
  logic [2:0] ale_cnt_q, ale_cnt_d;
  logic ale_d;
  logic vload_d, code_rd_d, pstb_n_d, aoe_n_d, rd_n_d, wr_n_d, woe_n_d;
  logic [15:0] vpc_d, eaddr_d;
  logic [16:0] caddr_d;
  logic [7:0] wdata_d, saddr_d;
  logic ssel_d, xhit, xvalid_d;
  logic fgo_d, ftool_d;
  logic [1:0] fop_d;
  logic [16:0] faddr;
  logic [15:0] limit;
  logic [2:0] ale_div;

  assign rst_n = rst_q[1];

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q <= 2'h0;
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
      pin_s1_q <= {i_six_clock_cycle_mode, i_boot_loader,
                   i_external_access_select};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Code space limit follows the captured boot bank and the variant size.
  assign limit = ldr_lat_q ? code_map_pkg::LDR_SIZE :
                 (i_app_16k ? code_map_pkg::APP_SIZE_16K :
                  code_map_pkg::APP_SIZE_32K);
  assign ale_div = six_lat_q ? code_map_pkg::ALE_DIV_SIX :
                   code_map_pkg::ALE_DIV_TWELVE;
  assign xhit = i_auxiliary_ram_en && i_data_wide &&
                (i_data_addr < code_map_pkg::AUX_SIZE);
  // The programming tool wins over in-system requests in the same cycle.
  assign ftool_d = i_tool_req;
  assign fop_d = ftool_d ? i_tool_op : i_isp_op;
  assign faddr = ftool_d ? i_tool_addr : i_isp_addr;

  always_comb begin
    state_d = state_q;
    start_d = start_q;
    ext_lat_d = ext_lat_q;
    ldr_lat_d = ldr_lat_q;
    six_lat_d = six_lat_q;
    ale_cnt_d = 3'h0;
    ale_d = 1'b0;
    vload_d = 1'b0;
    vpc_d = o_vector_pc;
    code_rd_d = 1'b0;
    caddr_d = o_code_addr;
    pstb_n_d = 1'b1;
    aoe_n_d = 1'b1;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    woe_n_d = 1'b1;
    eaddr_d = o_ext_addr;
    wdata_d = o_ext_wdata;
    ssel_d = 1'b0;
    saddr_d = o_scratch_addr;
    xvalid_d = 1'b0;
    fgo_d = 1'b0;
    case (state_q)
      code_map_pkg::ST_BOOT: begin
        start_d = start_q + 2'h1;
        if (start_q == code_map_pkg::START_WAIT) begin
          ext_lat_d = pin_s2_q[0];
          ldr_lat_d = pin_s2_q[1];
          six_lat_d = pin_s2_q[2];
          vload_d = 1'b1;
          vpc_d = code_map_pkg::RESET_PC;
          state_d = code_map_pkg::ST_RUN;
        end
      end
      code_map_pkg::ST_RUN: begin
        ale_cnt_d = (ale_cnt_q == ale_div - 3'h1) ? 3'h0 : ale_cnt_q + 3'h1;
        ale_d = (ale_cnt_d == 3'h0);
        if (i_int_accept) begin
          vload_d = 1'b1;
          vpc_d = code_map_pkg::VEC_FIRST +
                  {10'h000, i_int_idx, 3'h0};
        end
        if (i_fetch_req) begin
          if (ext_lat_q && (i_fetch_pc < limit)) begin
            code_rd_d = 1'b1;
            caddr_d = (ldr_lat_q ? code_map_pkg::LDR_BASE :
                       code_map_pkg::APP_BASE) + {1'b0, i_fetch_pc};
          end else begin
            pstb_n_d = 1'b0;
            aoe_n_d = 1'b0;
            eaddr_d = i_fetch_pc;
          end
        end else if (i_data_req) begin
          if (i_data_scratch) begin
            ssel_d = 1'b1;
            saddr_d = i_data_addr[7:0];
          end else if (xhit) begin
            xvalid_d = !i_data_we;
          end else begin
            aoe_n_d = 1'b0;
            eaddr_d = i_data_wide ? i_data_addr :
                      {8'h00, i_data_addr[7:0]};
            rd_n_d = i_data_we;
            wr_n_d = !i_data_we;
            woe_n_d = !i_data_we;
            wdata_d = i_data_wdata;
          end
        end
        fgo_d = (i_tool_req || i_isp_req) &&
                (fop_d != 2'h3);
      end
      default: begin
        state_d = code_map_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= code_map_pkg::ST_BOOT;
      start_q <= 2'h0;
      ext_lat_q <= 1'b0;
      ldr_lat_q <= 1'b0;
      six_lat_q <= 1'b0;
      ale_cnt_q <= 3'h0;
      o_addr_latch <= 1'b0;
      o_vector_load <= 1'b0;
      o_vector_pc <= 16'h0000;
      o_code_rd <= 1'b0;
      o_code_addr <= 17'h00000;
      o_prog_strobe_n <= 1'b1;
      o_ext_addr_oe_n <= 1'b1;
      o_ext_addr <= 16'h0000;
      o_ext_rd_n <= 1'b1;
      o_ext_wr_n <= 1'b1;
      o_ext_wdata <= 8'h00;
      o_ext_wdata_oe_n <= 1'b1;
      o_scratch_sel <= 1'b0;
      o_scratch_addr <= 8'h00;
      o_auxiliary_ram_rvalid <= 1'b0;
      o_flash_go <= 1'b0;
      o_flash_op <= 2'h0;
      o_flash_bank <= 2'h0;
      o_flash_page <= 7'h00;
      o_flash_byte <= 8'h00;
      o_flash_from_tool <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      ext_lat_q <= ext_lat_d;
      ldr_lat_q <= ldr_lat_d;
      six_lat_q <= six_lat_d;
      ale_cnt_q <= ale_cnt_d;
      o_addr_latch <= ale_d;
      o_vector_load <= vload_d;
      o_vector_pc <= vpc_d;
      o_code_rd <= code_rd_d;
      o_code_addr <= caddr_d;
      o_prog_strobe_n <= pstb_n_d;
      o_ext_addr_oe_n <= aoe_n_d;
      o_ext_addr <= eaddr_d;
      o_ext_rd_n <= rd_n_d;
      o_ext_wr_n <= wr_n_d;
      o_ext_wdata <= wdata_d;
      o_ext_wdata_oe_n <= woe_n_d;
      o_scratch_sel <= ssel_d;
      o_scratch_addr <= saddr_d;
      o_auxiliary_ram_rvalid <= xvalid_d;
      o_flash_go <= fgo_d;
      if (fgo_d) begin
        o_flash_op <= fop_d;
        o_flash_bank <= faddr[code_map_pkg::FL_BANK_LSB+:2];
        o_flash_page <= faddr[code_map_pkg::FL_PAGE_LSB+:7];
        o_flash_byte <= (fop_d == code_map_pkg::FL_OP_ERASE) ? 8'h00 :
                        faddr[7:0];
        o_flash_from_tool <= ftool_d;
      end
    end
  end

  // Auxiliary RAM with registered read data.
  aux_ram u_aux_ram (
    .i_mclk(i_mclk),
    .i_en(state_q == code_map_pkg::ST_RUN && !i_fetch_req && i_data_req &&
          !i_data_scratch && xhit),
    .i_we(i_data_we),
    .i_addr(i_data_addr[code_map_pkg::AUX_AW-1:0]),
    .i_wdata(i_data_wdata),
    .o_rdata(o_auxiliary_ram_rdata)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  logic run;
  assign run = (state_q == code_map_pkg::ST_RUN);

  property p_reset_vec;
    (!run && start_q == 2'h3) |=> o_vector_load && o_vector_pc == 16'h0000;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("bad reset pc");

  property p_vec;
    (run && i_int_accept) |=>
      o_vector_pc == {10'h000, $past(i_int_idx), 3'h3};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");

  property p_timer0;
    (run && i_int_accept && i_int_idx == 3'h1) |=> o_vector_pc == 16'h000b;
  endproperty
  a_timer0: assert property (p_timer0) else $error("bad timer0 vector");

  property p_ldr;
    (o_code_rd && ldr_lat_q) |-> o_code_addr >= 17'h10000;
  endproperty
  a_ldr: assert property (p_ldr) else $error("loader base missing");

  property p_limit;
    o_code_rd |-> $past(i_fetch_pc) < $past(limit);
  endproperty
  a_limit: assert property (p_limit) else $error("fetch past bank");

  property p_ext_all;
    (run && !ext_lat_q && i_fetch_req) |=> !o_prog_strobe_n && !o_code_rd;
  endproperty
  a_ext_all: assert property (p_ext_all) else $error("fetch not external");

  property p_lock;
    (run && $past(run)) |-> $stable(ext_lat_q) && $stable(ldr_lat_q);
  endproperty
  a_lock: assert property (p_lock) else $error("latched select moved");

  property p_quiet;
    o_code_rd |-> o_ext_rd_n && o_ext_wr_n && o_prog_strobe_n &&
                  o_ext_addr_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("strobe on internal");

  property p_ale;
    (six_lat_q && run && o_addr_latch) |=> !o_addr_latch ##1 !o_addr_latch
      ##1 o_addr_latch;
  endproperty
  a_ale: assert property (p_ale) else $error("latch rate wrong");

  property p_narrow;
    (run && !i_fetch_req && i_data_req && !i_data_scratch && !xhit &&
     !i_data_wide && !i_data_we) |=> !o_ext_rd_n && o_ext_addr[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow read wrong");

  property p_tool;
    (run && i_tool_req && i_isp_req && i_tool_op != 2'h3) |=>
      o_flash_go && o_flash_from_tool;
  endproperty
  a_tool: assert property (p_tool) else $error("tool not first");

  property p_sep;
    (i_data_req && !i_fetch_req) |=> !o_code_rd && o_prog_strobe_n;
  endproperty
  a_sep: assert property (p_sep) else $error("data hit code");

  c_ext_fetch: cover property (run && !o_prog_strobe_n);
  c_ldr_fetch: cover property (o_code_rd && ldr_lat_q);
  c_int: cover property (o_vector_load && o_vector_pc == 16'h0013);
  c_auxiliary_ram: cover property (o_auxiliary_ram_rvalid);
endmodule // code_map
`default_nettype wire

// *** include/code_map_pkg.sv ***
package code_map_pkg;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] VEC_FIRST = 16'h0003;
  localparam int VEC_STEP_LSB = 3;
  localparam logic [16:0] APP_BASE = 17'h00000;
  localparam logic [16:0] LDR_BASE = 17'h10000;
  localparam logic [15:0] APP_SIZE_32K = 16'h8000;
  localparam logic [15:0] APP_SIZE_16K = 16'h4000;
  localparam logic [15:0] LDR_SIZE = 16'h1000;
  localparam logic [15:0] AUX_SIZE = 16'h0400;
  localparam int AUX_AW = 10;
  localparam logic [2:0] ALE_DIV_SIX = 3'h3;
  localparam logic [2:0] ALE_DIV_TWELVE = 3'h6;
  localparam logic [1:0] START_WAIT = 2'h3;
  localparam int FL_BANK_LSB = 15;
  localparam int FL_PAGE_LSB = 8;
  localparam logic [1:0] FL_BANK_APP = 2'h0;
  localparam logic [1:0] FL_BANK_DATA = 2'h1;
  localparam logic [1:0] FL_BANK_LDR = 2'h2;
  localparam logic [1:0] FL_BANK_CFG = 2'h3;
  localparam logic [1:0] FL_OP_READ = 2'h0;
  localparam logic [1:0] FL_OP_PROG = 2'h1;
  localparam logic [1:0] FL_OP_ERASE = 2'h2;
  typedef enum logic {
    ST_BOOT = 1'b0,
    ST_RUN = 1'b1
  } map_state_t;
endpackage

// *** verilog/aux_ram.sv ***
`timescale 1ns/10ps
`default_nettype none
module aux_ram (
  input wire logic i_mclk,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [code_map_pkg::AUX_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1<<code_map_pkg::AUX_AW)-1];

  always_ff @(posedge i_mclk) begin
    if (i_en && i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_en && !i_we) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule // aux_ram
`default_nettype wire

// *** verification/ext_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
// Far-side memory: records program fetches and stores data writes.
module ext_mem (
  input wire logic i_mclk,
  input wire logic i_prog_strobe_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr_n,
  input wire logic [7:0] i_wdata,
  input wire logic i_wdata_oe_n
);
  logic [7:0] mem [logic [15:0]];
  logic [15:0] fetch_addr = '0;
  always @(posedge i_mclk) begin
    if (!i_prog_strobe_n) begin
      fetch_addr <= i_addr;
    end
    if (!i_wr_n && !i_wdata_oe_n) begin
      mem[i_addr] = i_wdata;
    end
  end
endmodule // ext_mem
`default_nettype wire

// *** verification/code_map_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module code_map_tb;
  logic i_mclk = '0, i_arst_n = '0, i_external_access_select = '1;
  logic i_boot_loader = '0, i_six_clock_cycle_mode = '0, i_app_16k = '0;
  logic i_fetch_req = '0, i_int_accept = '0, i_data_req = '0;
  logic i_data_scratch = '0, i_data_we = '0, i_data_wide = '0;
  logic i_auxiliary_ram_en = '0, i_tool_req = '0, i_isp_req = '0;
  logic [15:0] i_fetch_pc = '0, i_data_addr = '0;
  logic [2:0] i_int_idx = '0;
  logic [7:0] i_data_wdata = '0;
  logic [1:0] i_tool_op = '0, i_isp_op = '0;
  logic [16:0] i_tool_addr = '0, i_isp_addr = '0;
  logic o_vector_load, o_code_rd, o_prog_strobe_n, o_ext_addr_oe_n;
  logic o_ext_rd_n, o_ext_wr_n, o_ext_wdata_oe_n, o_addr_latch;
  logic o_scratch_sel, o_auxiliary_ram_rvalid, o_flash_go, o_flash_from_tool;
  logic [15:0] o_vector_pc, o_ext_addr;
  logic [16:0] o_code_addr;
  logic [7:0] o_ext_wdata, o_scratch_addr, o_auxiliary_ram_rdata, o_flash_byte;
  logic [1:0] o_flash_op, o_flash_bank;
  logic [6:0] o_flash_page;
  int err_total = 0;
  int cmp_count = 0;
  code_map i_dut (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_external_access_select(i_external_access_select),
    .i_boot_loader(i_boot_loader),
    .i_six_clock_cycle_mode(i_six_clock_cycle_mode),
    .i_app_16k(i_app_16k),
    .i_fetch_req(i_fetch_req),
    .i_fetch_pc(i_fetch_pc),
    .i_int_accept(i_int_accept),
    .i_int_idx(i_int_idx),
    .i_data_req(i_data_req),
    .i_data_scratch(i_data_scratch),
    .i_data_we(i_data_we),
    .i_data_wide(i_data_wide),
    .i_auxiliary_ram_en(i_auxiliary_ram_en),
    .i_data_addr(i_data_addr),
    .i_data_wdata(i_data_wdata),
    .i_tool_req(i_tool_req),
    .i_tool_op(i_tool_op),
    .i_tool_addr(i_tool_addr),
    .i_isp_req(i_isp_req),
    .i_isp_op(i_isp_op),
    .i_isp_addr(i_isp_addr),
    .o_vector_load(o_vector_load),
    .o_vector_pc(o_vector_pc),
    .o_code_rd(o_code_rd),
    .o_code_addr(o_code_addr),
    .o_prog_strobe_n(o_prog_strobe_n),
    .o_ext_addr(o_ext_addr),
    .o_ext_addr_oe_n(o_ext_addr_oe_n),
    .o_ext_rd_n(o_ext_rd_n),
    .o_ext_wr_n(o_ext_wr_n),
    .o_ext_wdata(o_ext_wdata),
    .o_ext_wdata_oe_n(o_ext_wdata_oe_n),
    .o_addr_latch(o_addr_latch),
    .o_scratch_sel(o_scratch_sel),
    .o_scratch_addr(o_scratch_addr),
    .o_auxiliary_ram_rdata(o_auxiliary_ram_rdata),
    .o_auxiliary_ram_rvalid(o_auxiliary_ram_rvalid),
    .o_flash_go(o_flash_go),
    .o_flash_op(o_flash_op),
    .o_flash_bank(o_flash_bank),
    .o_flash_page(o_flash_page),
    .o_flash_byte(o_flash_byte),
    .o_flash_from_tool(o_flash_from_tool)
  );
  ext_mem i_mem (.i_mclk(i_mclk), .i_prog_strobe_n(o_prog_strobe_n),
    .i_addr(o_ext_addr), .i_wr_n(o_ext_wr_n), .i_wdata(o_ext_wdata),
    .i_wdata_oe_n(o_ext_wdata_oe_n));
  always #25 i_mclk = ~i_mclk;
  task automatic chk(input string n, input logic [16:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic sel, ldr, six);
    @(posedge i_mclk);
    i_arst_n <= 1'h0;
    i_external_access_select <= sel;
    i_boot_loader <= ldr;
    i_six_clock_cycle_mode <= six;
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    repeat (20) begin
      @(posedge i_mclk);
      #1;
      if (o_vector_load === 1'h1) break;
    end
    chk("boot_load", 17'h1, o_vector_load);
    chk("boot_pc", 17'h0, o_vector_pc);
  endtask
  task automatic fchk(input logic [15:0] pc, input logic in,
                      input logic [16:0] a);
    @(posedge i_mclk);
    i_fetch_req <= 1'h1;
    i_fetch_pc <= pc;
    @(posedge i_mclk);
    i_fetch_req <= 1'h0;
    #1;
    chk("code_rd", in, o_code_rd);
    chk("prog_strobe_n", in, o_prog_strobe_n);
    chk("addr_oe_n", in, o_ext_addr_oe_n);
    if (in) begin
      chk("code_addr", a, o_code_addr);
    end else begin
      chk("ext_addr", a, 17'(o_ext_addr));
    end
  endtask
  task automatic dreq(input logic s, w, x, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge i_mclk);
    i_data_req <= 1'h1;
    i_data_scratch <= s;
    i_data_we <= w;
    i_data_wide <= x;
    i_data_addr <= a;
    i_data_wdata <= d;
    @(posedge i_mclk);
    i_data_req <= 1'h0;
    #1;
  endtask
  task automatic t_vectors;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_mclk);
      i_int_accept <= 1'h1;
      i_int_idx <= k[2:0];
      @(posedge i_mclk);
      i_int_accept <= 1'h0;
      #1;
      chk("vec_load", 17'h1, o_vector_load);
      chk("vec_pc", 17'h3 + 17'(8 * k), o_vector_pc);
    end
  endtask
  task automatic t_app;
    fchk(16'h7fff, 1'h1, 17'h07fff);
    fchk(16'h8000, 1'h0, 17'h08000);
    @(posedge i_mclk);
    #1;
    chk("mem_fetch", 17'h8000, i_mem.fetch_addr);
    @(posedge i_mclk);
    i_app_16k <= 1'h1;
    fchk(16'h3fff, 1'h1, 17'h03fff);
    fchk(16'h4000, 1'h0, 17'h04000);
  endtask
  task automatic t_data;
    @(posedge i_mclk);
    i_auxiliary_ram_en <= 1'h1;
    dreq(1'h1, 1'h0, 1'h0, 16'h005a, 8'h00);
    chk("scratch_sel", 17'h1, o_scratch_sel);
    chk("scratch_addr", 17'h5a, o_scratch_addr);
    chk("rd_n", 17'h1, o_ext_rd_n);
    dreq(1'h0, 1'h1, 1'h1, 16'h1234, 8'ha5);
    chk("wr_n", 17'h0, o_ext_wr_n);
    chk("ext_addr", 17'h1234, o_ext_addr);
    chk("wdata_oe_n", 17'h0, o_ext_wdata_oe_n);
    chk("wdata", 17'ha5, o_ext_wdata);
    @(posedge i_mclk);
    #1;
    chk("mem_data", 17'ha5, i_mem.mem[16'h1234]);
    dreq(1'h0, 1'h0, 1'h0, 16'h12ab, 8'h00);
    chk("rd_n", 17'h0, o_ext_rd_n);
    chk("ext_addr", 17'h00ab, o_ext_addr);
    dreq(1'h0, 1'h1, 1'h1, 16'h03ff, 8'h3c);
    chk("wr_n", 17'h1, o_ext_wr_n);
    dreq(1'h0, 1'h0, 1'h1, 16'h03ff, 8'h00);
    chk("auxiliary_ram_rvalid", 17'h1, o_auxiliary_ram_rvalid);
    chk("auxiliary_ram_rdata", 17'h3c, o_auxiliary_ram_rdata);
    chk("rd_n", 17'h1, o_ext_rd_n);
  endtask
  task automatic t_flash;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_mclk);
      i_tool_req <= ~k[2];
      i_isp_req <= k[2];
      i_tool_op <= k[1:0];
      i_isp_op <= k[1:0];
      i_tool_addr <= {2'h2, 7'h05, 8'h33};
      i_isp_addr <= {2'h1, 7'h7f, 8'hff};
      @(posedge i_mclk);
      i_tool_req <= 1'h0;
      i_isp_req <= 1'h0;
      #1;
      chk("flash_go", 17'(k[1:0] != 2'h3), o_flash_go);
      if (k[1:0] != 2'h3) begin
        chk("flash_op", 17'(k[1:0]), o_flash_op);
        chk("from_tool", 17'(!k[2]), o_flash_from_tool);
        chk("bank", k[2] ? 17'h1 : 17'h2, o_flash_bank);
        chk("page", k[2] ? 17'h7f : 17'h05, o_flash_page);
        chk("byte", k[1:0] == 2'h2 ? 17'h0 : (k[2] ? 17'hff : 17'h33),
          o_flash_byte);
      end
    end
    @(posedge i_mclk);
    i_tool_req <= 1'h1;
    i_isp_req <= 1'h1;
    i_tool_op <= 2'h1;
    i_isp_op <= 2'h2;
    @(posedge i_mclk);
    i_tool_req <= 1'h0;
    i_isp_req <= 1'h0;
    #1;
    chk("both_go", 17'h1, o_flash_go);
    chk("both_tool", 17'h1, o_flash_from_tool);
    chk("both_op", 17'h1, o_flash_op);
    chk("both_bank", 17'h2, o_flash_bank);
  endtask
  task automatic t_ale(input int p);
    int n;
    n = 0;
    repeat (12) begin
      @(posedge i_mclk);
      #1;
      if (o_addr_latch === 1'h1) break;
    end
    repeat (12) begin
      @(posedge i_mclk);
      #1;
      n++;
      if (o_addr_latch === 1'h1) break;
    end
    chk("latch_period", 17'(p), 17'(n));
  endtask
  initial begin
    do_reset(1'h1, 1'h0, 1'h0);
    t_vectors();
    t_app();
    t_data();
    t_flash();
    t_ale(6);
    @(posedge i_mclk);
    i_app_16k <= 1'h0;
    do_reset(1'h1, 1'h1, 1'h1);
    fchk(16'h0000, 1'h1, 17'h10000);
    fchk(16'h000b, 1'h1, 17'h1000b);
    fchk(16'h1000, 1'h0, 17'h01000);
    t_ale(3);
    do_reset(1'h0, 1'h0, 1'h0);
    fchk(16'h0000, 1'h0, 17'h00000);
    @(posedge i_mclk);
    i_external_access_select <= 1'h1;
    repeat (8) @(posedge i_mclk);
    fchk(16'h0010, 1'h0, 17'h00010);
    finish_test();
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule // code_map_tb
`default_nettype wire
